// ===== rtl/ifm_pkg.sv
// Package of constants and carrier types for the interrupt flag and mask block
package ifm_pkg;
   localparam int NUM_CH = 48;
   localparam int NUM_WORDS = 3;
   // Byte addresses of the registers
   localparam logic [11:0] OFF_MASK0 = 12'h000;
   localparam logic [11:0] OFF_MASK1 = 12'h004;
   localparam logic [11:0] OFF_MASK2 = 12'h008;
   localparam logic [11:0] OFF_UPPER0 = 12'h00c;
   localparam logic [11:0] OFF_UPPER1 = 12'h010;
   localparam logic [11:0] OFF_UPPER2 = 12'h014;
   localparam logic [11:0] OFF_SERVICE = 12'h018;
   localparam logic [11:0] OFF_PSW = 12'h01c;
   localparam logic [11:0] OFF_INT_PC = 12'h020;
   localparam logic [11:0] OFF_INT_PSW = 12'h024;
   localparam logic [11:0] OFF_NMI_PC = 12'h028;
   localparam logic [11:0] OFF_NMI_PSW = 12'h02c;
   localparam logic [11:0] OFF_DBG_PC = 12'h030;
   localparam logic [11:0] OFF_DBG_PSW = 12'h034;
   localparam logic [11:0] OFF_EVT_STAT = 12'h038;
   localparam logic [11:0] OFF_EVT_MASK = 12'h03c;
   localparam logic [11:0] OFF_CHAN_BASE = 12'h100;
   localparam logic [11:0] OFF_CHAN_END = 12'h1bc;
   // Channel control register fields
   localparam int CC_MASK_BIT = 6;
   localparam int CC_FLAG_BIT = 7;
   localparam int CC_PRIO_LSB = 0;
   localparam int CC_PRIO_W = 3;
   // Status word fields
   localparam int PSW_NP_BIT = 7;
   localparam int PSW_EP_BIT = 6;
   // Reset values and a mask word 2 write pattern
   localparam logic [15:0] MASK_RESET = 16'hffff;
   localparam logic [15:0] MASK2_HOLD_ONES = 16'hf8f0;
   localparam logic [31:0] PSW_RESET = 32'h0000_0020;
   // Event status bits
   localparam int EVT_ACK = 0;
   localparam int EVT_TRAP_RET = 1;
   localparam int EVT_DBG_DENY = 2;
   localparam int EVT_W = 3;

   // Core return request and answer
   typedef struct packed {
      logic valid;
      logic debug;
   } ifm_ret_req_t;
   typedef struct packed {
      logic valid;
      logic [31:0] pc;
      logic [31:0] processor_status_word;
   } ifm_ret_ans_t;
endpackage

// ===== rtl/ifm_ctrl.sv
// Interrupt request flags, shared mask storage, service priority and trap return
`timescale 1ns/1ns

module ifm_ctrl (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Interrupt requests and acknowledge from the core
   input wire logic [ifm_pkg::NUM_CH-1:0] req_i,
   input wire logic ack_i,
   input wire logic [5:0] ack_ch_i,
   // Exception entry and debug window events
   input wire logic nmi_enter_i,
   input wire logic [31:0] entry_pc_i,
   input wire logic illegal_op_i,
   input wire ifm_pkg::ifm_ret_req_t ret_req_i,
   output ifm_pkg::ifm_ret_ans_t ret_ans_o,
   // Pending, unmasked channels and event interrupt
   output logic [ifm_pkg::NUM_CH-1:0] pend_o,
   output logic irq_o
);
   logic [ifm_pkg::NUM_CH-1:0] flag_reg, flag_next;
   logic [ifm_pkg::NUM_CH-1:0] mask_reg, mask_next;
   logic [2:0] prio_reg [ifm_pkg::NUM_CH];
   logic [7:0] service_reg;
   logic [31:0] psw_reg, int_pc_reg, int_psw_reg, nmi_pc_reg, nmi_psw_reg;
   logic [31:0] dbg_pc_reg, dbg_psw_reg;
   logic dbg_open_reg;
   logic [ifm_pkg::EVT_W-1:0] evt_reg, evt_mask_reg, evt_set;
   logic [31:0] rdata;
   logic wr_en, rd_en, chan_hit, unmapped, dbg_hit;
   logic [5:0] chan_idx;
   logic [47:0] mask_words;
   logic use_nmi;

   // 16-bit mask word access through a word index
   function automatic logic [15:0] mask_word(input logic [47:0] m, input int w);
      return m[w*16 +: 16];
   endfunction

   // Access decode; every transfer completes in its first access cycle
   assign wr_en = psel_i && penable_i && pwrite_i;
   assign rd_en = psel_i && penable_i && !pwrite_i;
   assign chan_hit = paddr_i >= ifm_pkg::OFF_CHAN_BASE && paddr_i <= ifm_pkg::OFF_CHAN_END
      && paddr_i[1:0] == 2'b00;
   assign chan_idx = 6'((paddr_i - ifm_pkg::OFF_CHAN_BASE) >> 2);
   assign dbg_hit = paddr_i == ifm_pkg::OFF_DBG_PC || paddr_i == ifm_pkg::OFF_DBG_PSW;
   assign mask_words = mask_reg;
   assign use_nmi = psw_reg[ifm_pkg::PSW_NP_BIT] && !psw_reg[ifm_pkg::PSW_EP_BIT];

   // Read mux; unmapped and closed debug addresses answer with an error
   always_comb begin
      rdata = 32'h0000_0000;
      unmapped = 1'b0;
      if (chan_hit) begin
         rdata[ifm_pkg::CC_FLAG_BIT] = flag_reg[chan_idx];
         rdata[ifm_pkg::CC_MASK_BIT] = mask_reg[chan_idx];
         rdata[ifm_pkg::CC_PRIO_LSB +: ifm_pkg::CC_PRIO_W] = prio_reg[chan_idx];
      end else begin
         case (paddr_i)
            ifm_pkg::OFF_MASK0: rdata[15:0] = mask_word(mask_words, 0);
            ifm_pkg::OFF_MASK1: rdata[15:0] = mask_word(mask_words, 1);
            ifm_pkg::OFF_MASK2: rdata[15:0] = mask_word(mask_words, 2);
            ifm_pkg::OFF_UPPER0: rdata[7:0] = mask_words[15:8];
            ifm_pkg::OFF_UPPER1: rdata[7:0] = mask_words[31:24];
            ifm_pkg::OFF_UPPER2: rdata[7:0] = mask_words[47:40];
            ifm_pkg::OFF_SERVICE: rdata[7:0] = service_reg;
            ifm_pkg::OFF_PSW: rdata = psw_reg;
            ifm_pkg::OFF_INT_PC: rdata = int_pc_reg;
            ifm_pkg::OFF_INT_PSW: rdata = int_psw_reg;
            ifm_pkg::OFF_NMI_PC: rdata = nmi_pc_reg;
            ifm_pkg::OFF_NMI_PSW: rdata = nmi_psw_reg;
            ifm_pkg::OFF_DBG_PC: rdata = dbg_open_reg ? dbg_pc_reg : 32'h0000_0000;
            ifm_pkg::OFF_DBG_PSW: rdata = dbg_open_reg ? dbg_psw_reg : 32'h0000_0000;
            ifm_pkg::OFF_EVT_STAT: rdata[ifm_pkg::EVT_W-1:0] = evt_reg;
            ifm_pkg::OFF_EVT_MASK: rdata[ifm_pkg::EVT_W-1:0] = evt_mask_reg;
            default: unmapped = 1'b1;
         endcase
         if (dbg_hit && !dbg_open_reg) begin
            unmapped = 1'b1;
         end
      end
   end

   // Flags: requests set, acknowledge clears; a new request in the ack cycle wins
   always_comb begin
      flag_next = flag_reg;
      if (ack_i) begin
         flag_next[ack_ch_i] = 1'b0;
      end
      if (wr_en && chan_hit) begin
         flag_next[chan_idx] = pwdata_i[ifm_pkg::CC_FLAG_BIT];
      end
      flag_next = flag_next | req_i;
   end

   // One mask storage reached from the channel register and from the words
   always_comb begin
      mask_next = mask_reg;
      if (wr_en && chan_hit) begin
         mask_next[chan_idx] = pwdata_i[ifm_pkg::CC_MASK_BIT];
      end
      if (wr_en && paddr_i == ifm_pkg::OFF_MASK0) mask_next[15:0] = pwdata_i[15:0];
      if (wr_en && paddr_i == ifm_pkg::OFF_MASK1) mask_next[31:16] = pwdata_i[15:0];
      if (wr_en && paddr_i == ifm_pkg::OFF_MASK2) mask_next[47:32] = pwdata_i[15:0];
      if (wr_en && paddr_i == ifm_pkg::OFF_UPPER0) mask_next[15:8] = pwdata_i[7:0];
      if (wr_en && paddr_i == ifm_pkg::OFF_UPPER1) mask_next[31:24] = pwdata_i[7:0];
      if (wr_en && paddr_i == ifm_pkg::OFF_UPPER2) mask_next[47:40] = pwdata_i[7:0];
   end

   // Events: acknowledge, trap return, refused debug access
   assign evt_set = {(rd_en || wr_en) && dbg_hit && !dbg_open_reg, ret_ans_o.valid, ack_i};

   // Register bus and stored state
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         flag_reg <= '0;
         mask_reg <= {ifm_pkg::MASK_RESET, ifm_pkg::MASK_RESET, ifm_pkg::MASK_RESET};
         for (int i = 0; i < ifm_pkg::NUM_CH; i++) prio_reg[i] <= 3'h7;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
         evt_mask_reg <= '0;
      end else begin
         flag_reg <= flag_next;
         mask_reg <= mask_next;
         pready_o <= psel_i && !penable_i;
         pslverr_o <= psel_i && !penable_i && unmapped;
         // Read returns the state before any same-cycle ack: see service register
         prdata_o <= (psel_i && !penable_i && !pwrite_i) ? rdata : 32'h0000_0000;
         if (wr_en && chan_hit) prio_reg[chan_idx] <= pwdata_i[2:0];
         if (wr_en && paddr_i == ifm_pkg::OFF_EVT_MASK) evt_mask_reg <= pwdata_i[2:0];
      end
   end

   // Sticky events, cleared by a status read; a new event wins over the clear
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         evt_reg <= '0;
         irq_o <= 1'b0;
         pend_o <= '0;
      end else begin
         evt_reg <= ((rd_en && paddr_i == ifm_pkg::OFF_EVT_STAT) ? '0 : evt_reg) | evt_set;
         irq_o <= |(evt_reg & evt_mask_reg);
         pend_o <= flag_next & ~mask_next;
      end
   end

   // Acknowledge enters service; only a return through the interrupt pair leaves it
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         service_reg <= 8'h00;
         psw_reg <= ifm_pkg::PSW_RESET;
         int_pc_reg <= 32'h0000_0000;
         int_psw_reg <= 32'h0000_0000;
         nmi_pc_reg <= 32'h0000_0000;
         nmi_psw_reg <= 32'h0000_0000;
         dbg_pc_reg <= 32'h0000_0000;
         dbg_psw_reg <= 32'h0000_0000;
         dbg_open_reg <= 1'b0;
         ret_ans_o <= '0;
      end else begin
         ret_ans_o.valid <= 1'b0;
         if (ack_i) begin
            service_reg[prio_reg[ack_ch_i]] <= 1'b1;
            int_pc_reg <= entry_pc_i;
            int_psw_reg <= psw_reg;
            psw_reg[ifm_pkg::PSW_EP_BIT] <= 1'b0;
            psw_reg[ifm_pkg::PSW_NP_BIT] <= 1'b0;
         end else if (nmi_enter_i) begin
            nmi_pc_reg <= entry_pc_i;
            nmi_psw_reg <= psw_reg;
            psw_reg[ifm_pkg::PSW_NP_BIT] <= 1'b1;
         end else if (illegal_op_i) begin
            dbg_pc_reg <= entry_pc_i;
            dbg_psw_reg <= psw_reg;
            dbg_open_reg <= 1'b1;
         end else if (ret_req_i.valid && ret_req_i.debug) begin
            ret_ans_o <= '{valid: 1'b1, pc: dbg_pc_reg, processor_status_word: dbg_psw_reg};
            psw_reg <= dbg_psw_reg;
            dbg_open_reg <= 1'b0;
         end else if (ret_req_i.valid) begin
            // Pair choice follows the status flags as entry, acknowledge or software left them
            if (use_nmi) begin
               ret_ans_o <= '{valid: 1'b1, pc: nmi_pc_reg, processor_status_word: nmi_psw_reg};
               psw_reg <= nmi_psw_reg;
            end else begin
               ret_ans_o <= '{valid: 1'b1, pc: int_pc_reg, processor_status_word: int_psw_reg};
               psw_reg <= int_psw_reg;
               // Level 0 ranks highest, so retire the lowest set bit
               service_reg <= service_reg & (service_reg - 8'h01);
            end
         end else if (wr_en) begin
            if (paddr_i == ifm_pkg::OFF_PSW) psw_reg <= pwdata_i;
            if (paddr_i == ifm_pkg::OFF_INT_PC) int_pc_reg <= pwdata_i;
            if (paddr_i == ifm_pkg::OFF_INT_PSW) int_psw_reg <= pwdata_i;
            if (paddr_i == ifm_pkg::OFF_NMI_PC) nmi_pc_reg <= pwdata_i;
            if (paddr_i == ifm_pkg::OFF_NMI_PSW) nmi_psw_reg <= pwdata_i;
            if (paddr_i == ifm_pkg::OFF_DBG_PC && dbg_open_reg) dbg_pc_reg <= pwdata_i;
            if (paddr_i == ifm_pkg::OFF_DBG_PSW && dbg_open_reg) dbg_psw_reg <= pwdata_i;
         end
      end
   end

   // Checks
   a_ack_clears_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
      ack_i && !req_i[ack_ch_i] |=> !flag_reg[$past(ack_ch_i)])
      else $error("ack did not clear flag");
   a_shared_mask_bit: assert property (@(posedge core_clk_i) disable iff (rst_i)
      wr_en && chan_hit |=> mask_reg[$past(chan_idx)] == $past(pwdata_i[6]))
      else $error("channel mask write lost");
   a_upper_byte_view: assert property (@(posedge core_clk_i) disable iff (rst_i)
      rd_en && paddr_i == ifm_pkg::OFF_UPPER1 |-> prdata_o[7:0] == mask_reg[31:24])
      else $error("upper byte view wrong");
   a_debug_closed: assert property (@(posedge core_clk_i) disable iff (rst_i)
      rd_en && dbg_hit && !dbg_open_reg |-> prdata_o == 32'h0000_0000 && pslverr_o)
      else $error("debug pair readable while closed");
   a_nmi_return: assert property (@(posedge core_clk_i) disable iff (rst_i)
      ret_req_i.valid && !ret_req_i.debug && !ack_i && !nmi_enter_i && !illegal_op_i && use_nmi
      |=> ret_ans_o.valid && ret_ans_o.pc == $past(nmi_pc_reg))
      else $error("nmi return used wrong pair");
   a_service_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
      ack_i |=> service_reg[$past(prio_reg[ack_ch_i])])
      else $error("service bit not set");
   a_apb_one_wait: assert property (@(posedge core_clk_i) disable iff (rst_i)
      psel_i && !penable_i |=> pready_o) else $error("pready late");
   a_irq_level: assert property (@(posedge core_clk_i) disable iff (rst_i)
      irq_o == |($past(evt_reg) & $past(evt_mask_reg))) else $error("irq level wrong");
   c_ack_seen: cover property (@(posedge core_clk_i) ack_i);
   c_nmi_ret: cover property (@(posedge core_clk_i) ret_ans_o.valid && use_nmi);
   c_dbg_open: cover property (@(posedge core_clk_i) dbg_open_reg && rd_en && dbg_hit);
endmodule

// ===== tb/ifm_core_model.sv
// Core model: acknowledges channels, enters exceptions and requests returns
`timescale 1ns/1ns
module ifm_core_model (
   // Clock
   input wire logic core_clk_i,
   // Core side of the block
   input wire ifm_pkg::ifm_ret_ans_t ret_ans_i,
   output logic ack_o,
   output logic [5:0] ack_ch_o,
   output logic nmi_o,
   output logic ill_o,
   output logic [31:0] pc_o,
   output ifm_pkg::ifm_ret_req_t ret_o
);
   // Quiet at time zero
   initial begin
      ack_o = 1'b0;
      ack_ch_o = 6'h00;
      nmi_o = 1'b0;
      ill_o = 1'b0;
      pc_o = 32'h0000_0000;
      ret_o = '0;
   end

   // Acknowledge is never issued during a flag read by software
   task automatic ack(input logic [5:0] ch);
      @(posedge core_clk_i);
      ack_o <= 1'b1;
      ack_ch_o <= ch;
      @(posedge core_clk_i);
      ack_o <= 1'b0;
      ack_ch_o <= ~ch;
   endtask

   // Nmi entry or illegal opcode used only as debug entry
   task automatic enter(input logic nmi, input logic [31:0] pc);
      @(posedge core_clk_i);
      nmi_o <= nmi;
      ill_o <= ~nmi;
      pc_o <= pc;
      @(posedge core_clk_i);
      nmi_o <= 1'b0;
      ill_o <= 1'b0;
      pc_o <= ~pc; // Entry address is not held after the pulse
   endtask

   // Return request; the answer is waited for under a bound
   task automatic ret(input logic dbg, output ifm_pkg::ifm_ret_ans_t ans);
      @(posedge core_clk_i);
      ret_o.valid <= 1'b1;
      ret_o.debug <= dbg;
      @(posedge core_clk_i);
      ret_o.valid <= 1'b0;
      ret_o.debug <= ~dbg;
      ans = '0;
      // The answer is taken at the edge that samples it valid
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk_i);
         if (ret_ans_i.valid === 1'b1) begin
            ans = ret_ans_i;
            break;
         end
      end
   endtask
endmodule

// ===== tb/tb_ifm_ctrl.sv
// Self-checking testbench for the interrupt flag and mask block
`timescale 1ns/1ns
module tb_ifm_ctrl;
   logic core_clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic irq_o, ack_i, nmi_enter_i, illegal_op_i, err;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, entry_pc_i, rd;
   logic [47:0] req_i, pend_o;
   logic [5:0] ack_ch_i;
   ifm_pkg::ifm_ret_req_t ret_req_i;
   ifm_pkg::ifm_ret_ans_t ret_ans_o, ans;
   int err_count, n_tests;

   ifm_ctrl ifm_ctrl_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .req_i(req_i),
      .ack_i(ack_i), .ack_ch_i(ack_ch_i), .nmi_enter_i(nmi_enter_i),
      .entry_pc_i(entry_pc_i), .illegal_op_i(illegal_op_i), .ret_req_i(ret_req_i),
      .ret_ans_o(ret_ans_o), .pend_o(pend_o), .irq_o(irq_o));
   ifm_core_model ifm_core_model_inst (.core_clk_i(core_clk_i), .ret_ans_i(ret_ans_o),
      .ack_o(ack_i), .ack_ch_o(ack_ch_i), .nmi_o(nmi_enter_i), .ill_o(illegal_op_i),
      .pc_o(entry_pc_i), .ret_o(ret_req_i));

   // 25 MHz clock
   initial begin
      core_clk_i = 1'b0;
      forever #20 core_clk_i = ~core_clk_i;
   end

   task automatic close_out();
      if (err_count == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; read data and error are taken at the pready edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      // Wait for the edge that samples pready high, then release at that edge
      for (int i = 0; i < 8; i++) begin
         @(posedge core_clk_i);
         if (pready_o === 1'b1) break;
      end
      if (pready_o !== 1'b1) begin
         err_count++;
         close_out();
      end
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      pwdata_i <= ~d; // Stale data is not left on the bus
   endtask

   function automatic logic [11:0] chan(input int n);
      return ifm_pkg::OFF_CHAN_BASE + 12'(4 * n);
   endfunction

   task automatic settle();
      repeat (2) @(posedge core_clk_i);
      #1;
   endtask

   // Return through the core model; a missing answer ends the run
   task automatic do_ret(input logic dbg);
      ifm_core_model_inst.ret(dbg, ans);
      if (ans.valid !== 1'b1) begin
         err_count++;
         close_out();
      end
   endtask

   // Reset values and an unmapped address
   task automatic t_reset();
      apb(1'b0, ifm_pkg::OFF_MASK0, 32'h0);
      chk(rd, 32'h0000_ffff);
      apb(1'b0, ifm_pkg::OFF_PSW, 32'h0);
      chk(rd, ifm_pkg::PSW_RESET);
      apb(1'b0, 12'h040, 32'h0);
      chk({rd[30:0], err}, 32'h0000_0001);
   endtask

   // Shared mask storage and upper byte views
   task automatic t_share();
      apb(1'b1, chan(5), 32'h0000_0007);
      apb(1'b0, ifm_pkg::OFF_MASK0, 32'h0);
      chk(rd, 32'h0000_ffdf);
      apb(1'b1, ifm_pkg::OFF_MASK1, 32'h0000_5aff);
      apb(1'b0, ifm_pkg::OFF_UPPER1, 32'h0);
      chk(rd, 32'h0000_005a);
      apb(1'b1, ifm_pkg::OFF_UPPER0, 32'h0000_00a5);
      apb(1'b0, ifm_pkg::OFF_MASK0, 32'h0);
      chk(rd, 32'h0000_a5df);
      apb(1'b0, chan(24), 32'h0);
      chk(rd, 32'h0000_0007);
      apb(1'b1, ifm_pkg::OFF_MASK2, {16'h0, ifm_pkg::MASK2_HOLD_ONES | 16'h0005});
      apb(1'b0, ifm_pkg::OFF_UPPER2, 32'h0);
      chk(rd, 32'h0000_00f8);
   endtask

   // Request, acknowledge clear and the event interrupt
   task automatic t_ack();
      apb(1'b1, ifm_pkg::OFF_EVT_MASK, 32'h0);
      @(posedge core_clk_i);
      req_i <= 48'h0000_0000_0020;
      @(posedge core_clk_i);
      req_i <= 48'h0;
      settle();
      chk(32'(pend_o[5]), 32'h1);
      apb(1'b0, chan(5), 32'h0);
      chk(rd, 32'h0000_0087);
      ifm_core_model_inst.ack(6'd5);
      settle();
      chk(32'(pend_o[5]), 32'h0);
      apb(1'b0, chan(5), 32'h0);
      chk(rd, 32'h0000_0007);
      apb(1'b0, ifm_pkg::OFF_SERVICE, 32'h0);
      chk(rd, 32'h0000_0080);
      chk(32'(irq_o), 32'h0);
      apb(1'b1, ifm_pkg::OFF_EVT_MASK, 32'h0000_0001);
      settle();
      chk(32'(irq_o), 32'h1);
      apb(1'b0, ifm_pkg::OFF_EVT_STAT, 32'h0);
      chk(rd, 32'h0000_0001);
      settle();
      chk(32'(irq_o), 32'h0);
   endtask

   // Return picks the nmi pair only with nmi set and trap clear
   task automatic t_ret();
      ifm_core_model_inst.enter(1'b1, 32'h0000_1234);
      apb(1'b0, ifm_pkg::OFF_PSW, 32'h0);
      chk(rd & 32'h0000_00c0, 32'h0000_0080);
      do_ret(1'b0);
      chk(ans.pc, 32'h0000_1234);
      apb(1'b1, ifm_pkg::OFF_INT_PC, 32'h0000_5678);
      apb(1'b1, ifm_pkg::OFF_INT_PSW, 32'h0000_0020);
      apb(1'b1, ifm_pkg::OFF_PSW, 32'h0000_0040);
      do_ret(1'b0);
      chk({ans.pc[15:0], ans.processor_status_word[15:0]}, 32'h5678_0020);
      apb(1'b0, ifm_pkg::OFF_SERVICE, 32'h0);
      chk(rd, 32'h0000_0000);
      apb(1'b1, ifm_pkg::OFF_PSW, 32'h0000_00c0);
      do_ret(1'b0);
      chk(ans.pc, 32'h0000_5678);
   endtask

   // Debug pair is open only from illegal opcode to debug return
   task automatic t_dbg();
      apb(1'b0, ifm_pkg::OFF_DBG_PC, 32'h0);
      chk({rd[30:0], err}, 32'h0000_0001);
      ifm_core_model_inst.enter(1'b0, 32'h0000_0abc);
      apb(1'b0, ifm_pkg::OFF_DBG_PC, 32'h0);
      chk({rd[30:0], err}, 32'h0000_1578);
      do_ret(1'b1);
      chk(32'(ans.valid), 32'h1);
      apb(1'b0, ifm_pkg::OFF_DBG_PC, 32'h0);
      chk({rd[30:0], err}, 32'h0000_0001);
      apb(1'b0, ifm_pkg::OFF_EVT_STAT, 32'h0);
      chk(rd, 32'h0000_0006);
   endtask

   // Main sequence
   initial begin
      err_count = 0;
      n_tests = 0;
      rst_i = 1'b1;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = 12'h000;
      pwdata_i = 32'h0000_0000;
      req_i = 48'h0;
      repeat (6) @(posedge core_clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_share();
      t_ack();
      t_ret();
      t_dbg();
      close_out();
   end
endmodule
